// *** design/monitor_config_mask_registers.v ***
// Configuration, alarm limit and interrupt mask register bank of the monitor
`include "monitor_cfg_regs.vh"
module monitor_config_mask_registers (
  input  wire        i_clock,
  input  wire        i_rst_b,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata,
  output wire        o_rd_hit,
  input  wire [7:0]  i_int_temp,
  input  wire [7:0]  i_rem1_temp,
  input  wire [7:0]  i_rem2_temp,
  input  wire        i_alarm_enable,
  output reg         o_thermal_alarm_output,
  input  wire [11:0] i_pin_in,
  input  wire [11:0] i_pin_out,
  output wire [11:0] o_pin_oe,
  output wire [11:0] o_pin_drive,
  output wire [11:0] o_pin_active,
  output wire [7:0]  o_int_fan_start,
  output wire [7:0]  o_rem1_fan_start,
  output wire [7:0]  o_rem2_fan_start,
  output wire        o_nvm_read_mode,
  output wire        o_nvm_prog_mode,
  output wire        o_nvm_erase_mode,
  output wire        o_nvm_protected,
  output wire        o_nvm_prog_allowed,
  input  wire        i_busy,
  output wire        o_stretch_scl,
  input  wire [7:0]  i_evt_supply,
  input  wire [7:0]  i_evt_analog,
  input  wire [7:0]  i_evt_fan,
  input  wire        i_int_clear,
  output reg  [7:0]  o_pend_supply,
  output reg  [7:0]  o_pend_analog,
  output reg  [7:0]  o_pend_fan,
  output wire        o_irq
);

  // ****************************************
  // Storage
  // ****************************************
  reg  [7:0] pin_cfg_group_b;
  reg  [7:0] pin_cfg_group_c;
  reg  [7:0] pin_cfg_group_d;
  reg  [7:0] internal_alarm_limit;
  reg  [7:0] remote1_alarm_limit;
  reg  [7:0] remote2_alarm_limit;
  reg  [7:0] internal_fan_start_temp;
  reg  [7:0] remote1_fan_start_temp;
  reg  [7:0] remote2_fan_start_temp;
  reg  [7:0] nvm_control;
  reg  [7:0] factory_test_one;
  reg  [7:0] factory_test_two;
  reg  [7:0] irq_mask_supply_remote;
  reg  [7:0] irq_mask_analog_inputs;
  reg  [7:0] irq_mask_fan_tach;
  reg  [7:0] next_rdata;
  reg        next_hit;
  reg  [7:0] next_nvm;
  wire       wp_now;
  wire       write_nvm;

  assign write_nvm = i_wr_en && (i_addr == `OFS_NVM_CONTROL);
  assign wp_now    = nvm_control[`NVM_WP_BIT];

  // ****************************************
  // Nvm control next value
  // ****************************************
  always @* begin
    next_nvm = i_wdata;
    next_nvm[`NVM_WP_BIT] = wp_now | i_wdata[`NVM_WP_BIT];
    if (wp_now) begin
      next_nvm[`NVM_PROG_BIT]  = 1'b0;
      next_nvm[`NVM_ERASE_BIT] = 1'b0;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_cfg_group_b         <= `RST_ZERO;
      pin_cfg_group_c         <= `RST_ZERO;
      pin_cfg_group_d         <= `RST_ZERO;
      internal_alarm_limit    <= `RST_INT_ALARM_LIM;
      remote1_alarm_limit     <= `RST_REM_ALARM_LIM;
      remote2_alarm_limit     <= `RST_REM_ALARM_LIM;
      internal_fan_start_temp <= `RST_INT_FAN_START;
      remote1_fan_start_temp  <= `RST_REM_FAN_START;
      remote2_fan_start_temp  <= `RST_REM_FAN_START;
      nvm_control             <= `RST_ZERO;
      factory_test_one        <= `RST_ZERO;
      factory_test_two        <= `RST_ZERO;
      irq_mask_supply_remote  <= `RST_ZERO;
      irq_mask_analog_inputs  <= `RST_ZERO;
      irq_mask_fan_tach       <= `RST_ZERO;
    end else if (i_wr_en) begin
      case (i_addr)
        `OFS_PIN_CFG_B:      pin_cfg_group_b <= i_wdata;
        `OFS_PIN_CFG_C:      pin_cfg_group_c <= i_wdata;
        `OFS_PIN_CFG_D:      pin_cfg_group_d <= i_wdata;
        `OFS_INT_ALARM_LIM:  internal_alarm_limit <= i_wdata;
        `OFS_REM1_ALARM_LIM: remote1_alarm_limit <= i_wdata;
        `OFS_REM2_ALARM_LIM: remote2_alarm_limit <= i_wdata;
        `OFS_INT_FAN_START:  internal_fan_start_temp <= i_wdata;
        `OFS_REM1_FAN_START: remote1_fan_start_temp <= i_wdata;
        `OFS_REM2_FAN_START: remote2_fan_start_temp <= i_wdata;
        `OFS_NVM_CONTROL:    nvm_control <= next_nvm;
        `OFS_TEST_ONE:       factory_test_one <= i_wdata;
        `OFS_TEST_TWO:       factory_test_two <= i_wdata;
        `OFS_MASK_SUPPLY:    irq_mask_supply_remote <= i_wdata;
        `OFS_MASK_ANALOG:    irq_mask_analog_inputs <= i_wdata;
        `OFS_MASK_FAN:       irq_mask_fan_tach <= i_wdata;
        // factory byte and identity ignore writes
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    next_hit   = 1'b1;
    next_rdata = `RST_ZERO;
    case (i_addr)
      `OFS_PIN_CFG_B:      next_rdata = pin_cfg_group_b;
      `OFS_PIN_CFG_C:      next_rdata = pin_cfg_group_c;
      `OFS_PIN_CFG_D:      next_rdata = pin_cfg_group_d;
      `OFS_NVM_FACTORY:    next_rdata = `RST_ZERO;
      `OFS_INT_ALARM_LIM:  next_rdata = internal_alarm_limit;
      `OFS_REM1_ALARM_LIM: next_rdata = remote1_alarm_limit;
      `OFS_REM2_ALARM_LIM: next_rdata = remote2_alarm_limit;
      `OFS_INT_FAN_START:  next_rdata = internal_fan_start_temp;
      `OFS_REM1_FAN_START: next_rdata = remote1_fan_start_temp;
      `OFS_REM2_FAN_START: next_rdata = remote2_fan_start_temp;
      `OFS_NVM_CONTROL:    next_rdata = nvm_control;
      `OFS_TEST_ONE:       next_rdata = factory_test_one;
      `OFS_TEST_TWO:       next_rdata = factory_test_two;
      `OFS_MAKER_ID:       next_rdata = `MAKER_ID_VALUE;
      `OFS_REVISION:       next_rdata = {`REV_GENERATION, `REV_MINOR};
      `OFS_MASK_SUPPLY:    next_rdata = irq_mask_supply_remote;
      `OFS_MASK_ANALOG:    next_rdata = irq_mask_analog_inputs;
      `OFS_MASK_FAN:       next_rdata = irq_mask_fan_tach;
      default:             next_hit = 1'b0;
    endcase
  end

  assign o_rd_hit = i_rd_en & next_hit;

  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= `RST_ZERO;
    end else if (i_rd_en) begin
      o_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Thermal alarm
  // ****************************************
  // Strictly greater: a reading equal to the limit does not trip
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_thermal_alarm_output <= 1'b0;
    end else begin
      o_thermal_alarm_output <= i_alarm_enable &
        ((i_int_temp > internal_alarm_limit) |
         (i_rem1_temp > remote1_alarm_limit) |
         (i_rem2_temp > remote2_alarm_limit));
    end
  end

  // ****************************************
  // Pin groups
  // ****************************************
  pin_cfg_decode u_group_b (
    .i_cfg        (pin_cfg_group_b),
    .i_pin_out    (i_pin_out[3:0]),
    .i_pin_in     (i_pin_in[3:0]),
    .o_dir_out    (o_pin_oe[3:0]),
    .o_pin_drive  (o_pin_drive[3:0]),
    .o_pin_active (o_pin_active[3:0])
  );
  pin_cfg_decode u_group_c (
    .i_cfg        (pin_cfg_group_c),
    .i_pin_out    (i_pin_out[7:4]),
    .i_pin_in     (i_pin_in[7:4]),
    .o_dir_out    (o_pin_oe[7:4]),
    .o_pin_drive  (o_pin_drive[7:4]),
    .o_pin_active (o_pin_active[7:4])
  );
  pin_cfg_decode u_group_d (
    .i_cfg        (pin_cfg_group_d),
    .i_pin_out    (i_pin_out[11:8]),
    .i_pin_in     (i_pin_in[11:8]),
    .o_dir_out    (o_pin_oe[11:8]),
    .o_pin_drive  (o_pin_drive[11:8]),
    .o_pin_active (o_pin_active[11:8])
  );

  // ****************************************
  // Fan start and nvm controls
  // ****************************************
  assign o_int_fan_start  = internal_fan_start_temp;
  assign o_rem1_fan_start = remote1_fan_start_temp;
  assign o_rem2_fan_start = remote2_fan_start_temp;
  assign o_nvm_read_mode    = nvm_control[`NVM_READ_BIT];
  assign o_nvm_prog_mode    = nvm_control[`NVM_PROG_BIT] & ~wp_now;
  assign o_nvm_erase_mode   = nvm_control[`NVM_ERASE_BIT] & ~wp_now;
  assign o_nvm_protected    = wp_now;
  assign o_nvm_prog_allowed = ~wp_now;
  // stretch only when enabled and busy
  assign o_stretch_scl = nvm_control[`NVM_STRETCH_BIT] & i_busy;

  // ****************************************
  // Pending events and masking
  // ****************************************
  // Events set pending regardless of mask so status stays visible
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pend_supply <= `RST_ZERO;
      o_pend_analog <= `RST_ZERO;
      o_pend_fan    <= `RST_ZERO;
    end else if (i_int_clear) begin
      // clear, but new events still win
      o_pend_supply <= i_evt_supply;
      o_pend_analog <= i_evt_analog;
      o_pend_fan    <= i_evt_fan;
    end else begin
      o_pend_supply <= o_pend_supply | i_evt_supply;
      o_pend_analog <= o_pend_analog | i_evt_analog;
      o_pend_fan    <= o_pend_fan | i_evt_fan;
    end
  end

  assign o_irq = |(o_pend_supply & ~irq_mask_supply_remote) |
                 |(o_pend_analog & ~irq_mask_analog_inputs) |
                 |(o_pend_fan & ~irq_mask_fan_tach);

endmodule

// *** shared/monitor_cfg_regs.vh ***
// Register offsets, field positions and reset values for the monitor config bank
`ifndef MONITOR_CFG_REGS_VH
`define MONITOR_CFG_REGS_VH

// ****************************************
// Offsets
// ****************************************
`define OFS_PIN_CFG_B       8'h09
`define OFS_PIN_CFG_C       8'h0a
`define OFS_PIN_CFG_D       8'h0b
`define OFS_NVM_FACTORY     8'h0c
`define OFS_INT_ALARM_LIM   8'h0d
`define OFS_REM1_ALARM_LIM  8'h0e
`define OFS_REM2_ALARM_LIM  8'h0f
`define OFS_INT_FAN_START   8'h10
`define OFS_REM1_FAN_START  8'h11
`define OFS_REM2_FAN_START  8'h12
`define OFS_NVM_CONTROL     8'h13
`define OFS_TEST_ONE        8'h14
`define OFS_TEST_TWO        8'h15
`define OFS_MAKER_ID        8'h16
`define OFS_REVISION        8'h17
`define OFS_MASK_SUPPLY     8'h18
`define OFS_MASK_ANALOG     8'h19
`define OFS_MASK_FAN        8'h1a

// ****************************************
// Reset values
// ****************************************
`define RST_ZERO            8'h00
`define RST_INT_ALARM_LIM   8'h37
`define RST_REM_ALARM_LIM   8'h50
`define RST_INT_FAN_START   8'h28
`define RST_REM_FAN_START   8'h40
// Arbitrary identity values
`define MAKER_ID_VALUE      8'h5a
`define REV_GENERATION      4'h3
`define REV_MINOR           4'h0

// ****************************************
// Field positions of nvm control and pin counts
// ****************************************
`define NVM_READ_BIT        0
`define NVM_PROG_BIT        1
`define NVM_ERASE_BIT       2
`define NVM_WP_BIT          3
`define NVM_STRETCH_BIT     7
`define PINS_PER_GROUP      4
`define PIN_COUNT           12

`endif

// *** design/pin_cfg_decode.v ***
// Split a pin configuration byte into direction and polarity per pin
`include "monitor_cfg_regs.vh"
module pin_cfg_decode (
  input  wire [7:0] i_cfg,
  input  wire [3:0] i_pin_out,
  input  wire [3:0] i_pin_in,
  output wire [3:0] o_dir_out,
  output wire [3:0] o_pin_drive,
  output wire [3:0] o_pin_active
);
  genvar g;
  generate
    for (g = 0; g < `PINS_PER_GROUP; g = g + 1) begin : pin
      assign o_dir_out[g]    = i_cfg[2*g];
      assign o_pin_drive[g]  = i_cfg[2*g+1] ? i_pin_out[g] : ~i_pin_out[g];
      assign o_pin_active[g] = i_cfg[2*g+1] ? i_pin_in[g] : ~i_pin_in[g];
    end
  endgenerate
endmodule

// *** verif/monitor_cfg_host.sv ***
// Host model issuing single-byte register reads and writes
module monitor_cfg_host (
  input  wire        i_clock,
  input  wire  [7:0] i_rdata,
  output logic       o_wr_en,
  output logic       o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'hff;
  end

  // Released lines show the inverse, never a stale value
  task write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_wr_en <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr_en <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  task read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge i_clock);
    o_rd_en <= 1'b0;
    o_addr  <= ~a;
    #1 d = i_rdata;
  endtask
endmodule

// *** verif/monitor_config_mask_registers_sva.sv ***
// Concurrent property checker for the monitor config and mask register bank
`include "monitor_cfg_regs.vh"
module monitor_cfg_regs_checker (
  input wire        i_clock,
  input wire        i_rst_b,
  input wire        i_wr_en,
  input wire        i_rd_en,
  input wire [7:0]  i_addr,
  input wire [7:0]  o_rdata,
  input wire        o_rd_hit,
  input wire [7:0]  i_int_temp,
  input wire [7:0]  i_rem1_temp,
  input wire [7:0]  i_rem2_temp,
  input wire        i_alarm_enable,
  input wire        o_thermal_alarm_output,
  input wire [11:0] o_pin_oe,
  input wire        o_nvm_prog_mode,
  input wire        o_nvm_erase_mode,
  input wire        o_nvm_protected,
  input wire        i_busy,
  input wire        o_stretch_scl,
  input wire [7:0]  i_evt_supply,
  input wire [7:0]  i_evt_analog,
  input wire [7:0]  i_evt_fan,
  input wire        i_int_clear,
  input wire [7:0]  o_pend_supply,
  input wire [7:0]  o_pend_analog,
  input wire [7:0]  o_pend_fan,
  input wire        o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // ****************************************
  // Properties
  // ****************************************
  sequence s_read_id;
    i_rd_en && i_addr == `OFS_MAKER_ID;
  endsequence
  sequence s_clear_quiet;
    i_int_clear && i_evt_supply == 8'h00 && i_evt_analog == 8'h00 && i_evt_fan == 8'h00;
  endsequence

  AST_RD_HIT: assert property (o_rd_hit == (i_rd_en && i_addr >= 8'h09 && i_addr <= 8'h1a))
    else $error("read hit does not match the register map");
  AST_PIN_OE_WRITE: assert property (!$stable(o_pin_oe) |->
    $past(i_wr_en) && $past(i_addr) inside {8'h09, 8'h0a, 8'h0b})
    else $error("pin direction changed without a pin config write");
  AST_RD_MAKER: assert property (s_read_id |=> o_rdata == `MAKER_ID_VALUE)
    else $error("identity byte read wrong");
  AST_ALARM_HOT: assert property (i_alarm_enable && (i_int_temp == 8'hff ||
    i_rem1_temp == 8'hff || i_rem2_temp == 8'hff) |=> o_thermal_alarm_output)
    else $error("alarm missing for a full scale reading");
  AST_ALARM_OFF: assert property (!i_alarm_enable |=> !o_thermal_alarm_output)
    else $error("alarm raised while disabled");
  AST_PROT_HOLD: assert property (o_nvm_protected |=> o_nvm_protected)
    else $error("write protect cleared without reset");
  AST_PROT_GATE: assert property (o_nvm_protected |->
    !o_nvm_prog_mode && !o_nvm_erase_mode)
    else $error("program or erase mode while protected");
  AST_STRETCH: assert property (o_stretch_scl |-> i_busy)
    else $error("clock stretched while not busy");
  AST_IRQ_SRC: assert property (o_irq |->
    (o_pend_supply | o_pend_analog | o_pend_fan) != 8'h00)
    else $error("interrupt with nothing pending");
  AST_FAN_PEND: assert property (i_evt_fan != 8'h00 |=>
    (o_pend_fan & $past(i_evt_fan)) == $past(i_evt_fan))
    else $error("fan event did not pend");
  AST_CLEAR: assert property (s_clear_quiet |=>
    o_pend_supply == 8'h00 && o_pend_analog == 8'h00 && o_pend_fan == 8'h00)
    else $error("pending bits survived a clear");
endmodule

bind monitor_config_mask_registers monitor_cfg_regs_checker i_chk (.*);

// *** verif/monitor_config_mask_registers_test.sv ***
// Self-checking bench for the monitor configuration and mask register bank
`include "monitor_cfg_regs.vh"
module monitor_config_mask_registers_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 0, i_rst_b = 0, i_alarm_enable = 0, i_busy = 0, i_int_clear = 0;
  logic i_wr_en, i_rd_en, o_rd_hit, o_thermal_alarm_output, o_nvm_read_mode, o_nvm_prog_mode;
  logic o_nvm_erase_mode, o_nvm_protected, o_nvm_prog_allowed, o_stretch_scl, o_irq;
  logic [7:0] i_addr, i_wdata, o_rdata, i_int_temp = 0, i_rem1_temp = 0, i_rem2_temp = 0;
  logic [7:0] o_int_fan_start, o_rem1_fan_start, o_rem2_fan_start, i_evt_supply = 0;
  logic [7:0] i_evt_analog = 0, i_evt_fan = 0, o_pend_supply, o_pend_analog, o_pend_fan, rd;
  logic [11:0] i_pin_in = 0, i_pin_out = 12'h00f, o_pin_oe, o_pin_drive, o_pin_active;
  int fails = 0;
  int samples_checked = 0;

  always #5 i_clock = ~i_clock;
  monitor_config_mask_registers i_dut (.*);
  monitor_cfg_host i_host (.i_clock(i_clock), .i_rdata(o_rdata), .o_wr_en(i_wr_en),
    .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.read_reg(a, rd);
    check("register read", 32'(exp), 32'(rd));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    logic [7:0] rst_v [9:26];
    rst_v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h37, 8'h50, 8'h50, 8'h28, 8'h40, 8'h40, 8'h00,
      8'h00, 8'h00, `MAKER_ID_VALUE, {`REV_GENERATION, `REV_MINOR}, 8'h00, 8'h00, 8'h00};
    for (int a = 9; a <= 26; a++) begin
      // Factory test bytes and nvm control skipped here
      if (a >= 19 && a <= 21) continue;
      rdchk(a[7:0], rst_v[a]);
      i_host.write_reg(a[7:0], a[7:0] ^ 8'h5c);
      // Read-only places keep their value
      rdchk(a[7:0], (a == 12 || a >= 22 && a <= 23) ? rst_v[a] : a[7:0] ^ 8'h5c);
    end
    rdchk(8'h1b, 8'h00);
    check("fan start", 32'h4c4d4e,
      32'({o_int_fan_start, o_rem1_fan_start, o_rem2_fan_start}));
  endtask
  task t_pins;
    i_host.write_reg(8'h09, 8'h99);
    #1 check("pin oe", 32'hfe5, 32'(o_pin_oe));
    check("pin drive", 32'heea, 32'(o_pin_drive));
    check("pin active", 32'hee5, 32'(o_pin_active));
    @(posedge i_clock);
    i_pin_in <= 12'hfff;
    #1 check("pin active", 32'h11a, 32'(o_pin_active));
  endtask
  task temps(input logic [7:0] t0, t1, t2, input logic en, exp);
    @(posedge i_clock);
    i_int_temp <= t0;
    i_rem1_temp <= t1;
    i_rem2_temp <= t2;
    i_alarm_enable <= en;
    repeat (2) @(posedge i_clock);
    #1 check("thermal alarm", 32'(exp), 32'(o_thermal_alarm_output));
  endtask
  task t_alarm;
    temps(8'h51, 8'h00, 8'h00, 1'b1, 1'b0);
    temps(8'h52, 8'h00, 8'h00, 1'b1, 1'b1);
    temps(8'hff, 8'h00, 8'h00, 1'b0, 1'b0);
    temps(8'h00, 8'h53, 8'h53, 1'b1, 1'b1);
    temps(8'h00, 8'h52, 8'h54, 1'b1, 1'b1);
    temps(8'hff, 8'h52, 8'h53, 1'b1, 1'b1);
  endtask
  task nvm(input logic [7:0] d, input logic [5:0] exp);
    i_host.write_reg(8'h13, d);
    #1 check("nvm modes", 32'(exp), 32'({o_nvm_read_mode, o_nvm_prog_mode,
      o_nvm_erase_mode, o_nvm_protected, o_nvm_prog_allowed, o_stretch_scl}));
  endtask
  task t_nvm;
    // Stretch enabled first, test bits kept zero
    nvm(8'h87, 6'b111010);
    @(posedge i_clock);
    i_busy <= 1'b1;
    #1 check("stretch", 32'h1, 32'(o_stretch_scl));
    nvm(8'h8f, 6'b100101);
    nvm(8'h06, 6'b000100);
    rdchk(8'h13, 8'h08);
  endtask
  task evt(input logic [7:0] s, a, f, input logic clr);
    @(posedge i_clock);
    i_evt_supply <= s;
    i_evt_analog <= a;
    i_evt_fan <= f;
    i_int_clear <= clr;
    @(posedge i_clock);
    {i_evt_supply, i_evt_analog, i_evt_fan, i_int_clear} <= 25'h0;
    #1;
  endtask
  task irqchk(input logic [24:0] exp);
    check("pending", 32'(exp), 32'({o_pend_supply, o_pend_analog, o_pend_fan, o_irq}));
  endtask
  task t_irq;
    i_host.write_reg(8'h18, 8'h00);
    i_host.write_reg(8'h1a, 8'h04);
    evt(8'h00, 8'h00, 8'h04, 1'b0);
    irqchk({24'h000004, 1'b0});
    evt(8'h01, 8'h00, 8'h00, 1'b0);
    irqchk({24'h010004, 1'b1});
    evt(8'h00, 8'h01, 8'h00, 1'b1);
    irqchk({24'h000100, 1'b0});
    i_host.write_reg(8'h19, 8'h00);
    #1 irqchk({24'h000100, 1'b1});
    evt(8'h00, 8'h00, 8'h00, 1'b1);
    irqchk({24'h000000, 1'b0});
  endtask
  task t_reset;
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    rdchk(8'h13, 8'h00);
    rdchk(8'h0d, `RST_INT_ALARM_LIM);
  endtask

  task stop_test;
    $display("Checks made %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_regs();
    t_pins();
    t_alarm();
    t_nvm();
    t_irq();
    t_reset();
    stop_test();
  end
  // Whole run needs about 150 cycles
  initial begin
    #100us;
    fails++;
    stop_test();
  end
endmodule
